// [rtl/mpxfr_map.vh]
// Purpose: constants for the transfer-cycle controller of a dual-port video memory
// Assumes: 50 MHz system clock, all memory pins driven from flip-flops
// Notes:   times in ns, cycle counts derived from them
`ifndef MPXFR_MAP_VH
`define MPXFR_MAP_VH
`define MPXFR_CLK_NS        20
`define MPXFR_T_RAS_NS      80
`define MPXFR_T_CAS_NS      40
`define MPXFR_T_PRE_NS      60
`define MPXFR_T_TSD_NS      40
`define MPXFR_T_SRD_NS      40
`define MPXFR_T_STS_NS      40
`define MPXFR_CYC_RAS       ((`MPXFR_T_RAS_NS + `MPXFR_CLK_NS - 1) / `MPXFR_CLK_NS)
`define MPXFR_CYC_CAS       ((`MPXFR_T_CAS_NS + `MPXFR_CLK_NS - 1) / `MPXFR_CLK_NS)
`define MPXFR_CYC_PRE       ((`MPXFR_T_PRE_NS + `MPXFR_CLK_NS - 1) / `MPXFR_CLK_NS)
`define MPXFR_CYC_TSD       ((`MPXFR_T_TSD_NS + `MPXFR_CLK_NS - 1) / `MPXFR_CLK_NS)
`define MPXFR_CYC_SRD       ((`MPXFR_T_SRD_NS + `MPXFR_CLK_NS - 1) / `MPXFR_CLK_NS)
`define MPXFR_CYC_STS       ((`MPXFR_T_STS_NS + `MPXFR_CLK_NS - 1) / `MPXFR_CLK_NS)
// command codes on CMD_OP
`define MPXFR_OP_RT         2'h0
`define MPXFR_OP_WT         2'h1
`define MPXFR_OP_SRT        2'h2
`define MPXFR_OP_SWT        2'h3
`define MPXFR_ALL_MASKED    8'h00
`define MPXFR_SC_DIV        4'h3
`endif

// [rtl/mpxfr_fifo.v]
// Purpose: synchronous FIFO for serial write data
// Assumes: single clock, synchronous active-high reset
// Notes:   read data come out of a register; depth a power of two
`timescale 1ns/1ns
`default_nettype none
module mpxfr_fifo #(
  parameter WIDTH = 8,
  parameter ADDR  = 4
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  localparam DEPTH = 1 << ADDR;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR:0]    wr_q;
  reg [ADDR:0]    rd_q;
  wire            empty;
  wire            push;
  wire            pop;
  wire [ADDR:0]   wr_nx;
  wire [ADDR:0]   rd_nx;
  assign empty    = (wr_q == rd_q);
  // ready is registered from the next pointers, so the port sees a flop
  assign push     = in_valid && in_ready;
  // output register refills when drained or empty
  assign pop      = !empty && (!out_valid || out_ready);
  assign wr_nx    = wr_q + {{ADDR{1'b0}}, push};
  assign rd_nx    = rd_q + {{ADDR{1'b0}}, pop};
  always @(posedge clk) begin
    if (push) begin
      mem[wr_q[ADDR-1:0]] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      wr_q      <= {(ADDR+1){1'b0}};
      rd_q      <= {(ADDR+1){1'b0}};
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      wr_q     <= wr_nx;
      rd_q     <= rd_nx;
      in_ready <= !((wr_nx[ADDR-1:0] == rd_nx[ADDR-1:0]) && (wr_nx[ADDR] != rd_nx[ADDR]));
      if (pop) begin
        out_data  <= mem[rd_q[ADDR-1:0]];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/mpxfr_ctrl.v]
// Purpose: host-side controller issuing transfer cycles and serial writes to a video memory
// Assumes: 50 MHz CLK_SYS, synchronous active-high RESET, memory pins asynchronous
// Notes:   serial write data pass a 16-word FIFO; serial clock made by a divider enable
//
// Operation
// - controller may align output enable rise with serial clock fall.
// - after write transfer, read transfer keeps serial clock still for delay.
// - controller issues a full write transfer, masked with CMD_MASK, before shifting serial input.
// - between write transfers serial clock static until delay after row strobe rise.
// - controller performs a normal transfer before any split transfer.
// - controller never runs a transfer with column strobe held high.
// - controller issues split transfers without waiting out the half-switch window.
// - normal transfer after splits waits split setup after flag toggle.
// - avoid boundary changes while serial counter sits on boundary end address.
`timescale 1ns/1ns
`default_nettype none
`include "mpxfr_map.vh"
module mpxfr_ctrl #(
  parameter ROW_W  = 9,
  parameter COL_W  = 9,
  parameter FIFO_A = 4
) (
  input  wire             CLK_SYS,
  input  wire             RESET,
  input  wire             CMD_VALID,
  input  wire [1:0]       CMD_OP,
  input  wire [ROW_W-1:0] CMD_ROW,
  input  wire [COL_W-1:0] CMD_COL,
  input  wire [7:0]       CMD_MASK,
  output reg              CMD_READY,
  output reg              CMD_ERR,
  input  wire             WR_VALID,
  output wire             WR_READY,
  input  wire [7:0]       WR_DATA,
  output reg              SERIAL_IS_INPUT,
  output reg              row_strobe_n,
  output reg              column_strobe_n,
  output reg              transfer_output_enable_n,
  output reg              write_mask_enable_n,
  output reg              special_function_select,
  output reg  [8:0]       address,
  output reg  [7:0]       mask_data_lines,
  output reg              mask_data_oe,
  output reg              serial_shift_clock,
  output reg  [7:0]       serial_data_io_out,
  output reg              serial_data_io_oe,
  input  wire             active_half_flag
);
  localparam S_IDLE = 5'h01;
  localparam S_WAIT = 5'h02;
  localparam S_RAS  = 5'h04;
  localparam S_CAS  = 5'h08;
  localparam S_PRE  = 5'h10;

  // cycle counts cut to the counter width on purpose
  localparam integer RAS_I   = `MPXFR_CYC_RAS;
  localparam integer CAS_I   = `MPXFR_CYC_CAS;
  localparam integer END_I   = `MPXFR_CYC_CAS + `MPXFR_CYC_TSD;
  localparam integer PRE_I   = `MPXFR_CYC_PRE;
  localparam integer SRD_I   = `MPXFR_CYC_SRD;
  localparam integer STS_I   = `MPXFR_CYC_STS;
  localparam [3:0]   CYC_RAS = RAS_I[3:0];
  localparam [3:0]   CYC_ADR = CYC_RAS - 4'h1;
  localparam [3:0]   CYC_CAS = CAS_I[3:0];
  localparam [3:0]   CYC_END = END_I[3:0];
  localparam [3:0]   CYC_PRE = PRE_I[3:0];
  localparam [3:0]   CYC_SRD = SRD_I[3:0];
  localparam [3:0]   CYC_STS = STS_I[3:0];

  reg [4:0]       state_q;
  reg [3:0]       cnt_q;
  reg [1:0]       op_q;
  reg [ROW_W-1:0] row_q;
  reg [COL_W-1:0] col_q;
  reg [7:0]       mask_q;
  reg             normal_done_q;
  reg             last_wr_q;
  reg             qsf_s1_q;
  reg             qsf_s2_q;
  reg             qsf_s3_q;
  reg [3:0]       sts_q;
  reg [3:0]       div_q;
  reg             sc_en_q;
  wire            f_valid;
  wire            f_ready;
  wire [7:0]      f_data;
  wire            is_split;
  wire            cmd_bad;
  wire            qsf_edge;
  wire            shift_ok;

  assign is_split = CMD_OP[1];
  // split before any normal transfer is refused
  // normal first
  assign cmd_bad  = is_split && !normal_done_q;
  assign qsf_edge = qsf_s2_q ^ qsf_s3_q;
  // serial clock runs only in input mode while idle, so transfers see it static
  // clock static in cycle
  assign shift_ok = SERIAL_IS_INPUT && (state_q == S_IDLE) && !CMD_VALID;
  assign f_ready  = shift_ok && sc_en_q && !serial_shift_clock;

  mpxfr_fifo #(
    .WIDTH(8),
    .ADDR (FIFO_A)
  ) u_fifo (
    .clk      (CLK_SYS),
    .rst      (RESET),
    .in_valid (WR_VALID),
    .in_ready (WR_READY),
    .in_data  (WR_DATA),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data (f_data)
  );

  always @(posedge CLK_SYS) begin
    if (RESET) begin
      qsf_s1_q <= 1'b0;
      qsf_s2_q <= 1'b0;
      qsf_s3_q <= 1'b0;
      sts_q    <= 4'h0;
      div_q    <= 4'h0;
      sc_en_q  <= 1'b0;
    end else begin
      qsf_s1_q <= active_half_flag;
      qsf_s2_q <= qsf_s1_q;
      qsf_s3_q <= qsf_s2_q;
      if (qsf_edge) begin
        sts_q <= CYC_STS;
      end else if (sts_q != 4'h0) begin
        sts_q <= sts_q - 4'h1;
      end
      sc_en_q <= (div_q == `MPXFR_SC_DIV);
      div_q   <= (div_q == `MPXFR_SC_DIV) ? 4'h0 : div_q + 4'h1;
    end
  end

  always @(posedge CLK_SYS) begin
    if (RESET) begin
      state_q                  <= S_IDLE;
      cnt_q                    <= 4'h0;
      op_q                     <= `MPXFR_OP_RT;
      row_q                    <= {ROW_W{1'b0}};
      col_q                    <= {COL_W{1'b0}};
      mask_q                   <= 8'h00;
      normal_done_q            <= 1'b0;
      last_wr_q                <= 1'b0;
      CMD_READY                <= 1'b0;
      CMD_ERR                  <= 1'b0;
      SERIAL_IS_INPUT          <= 1'b0;
      row_strobe_n             <= 1'b1;
      column_strobe_n          <= 1'b1;
      transfer_output_enable_n <= 1'b1;
      write_mask_enable_n      <= 1'b1;
      special_function_select  <= 1'b0;
      address                  <= 9'h000;
      mask_data_lines          <= 8'h00;
      mask_data_oe             <= 1'b0;
      serial_shift_clock       <= 1'b0;
      serial_data_io_out       <= 8'h00;
      serial_data_io_oe        <= 1'b0;
    end else begin
      CMD_ERR   <= 1'b0;
      CMD_READY <= 1'b0;
      // serial write shifting: data load on the same edge the clock rises, rise latches it
      if (sc_en_q) begin
        if (f_ready && f_valid) begin
          serial_data_io_out <= f_data;
          serial_shift_clock <= 1'b1;
        end else begin
          serial_shift_clock <= 1'b0;
        end
      end
      // drive serial lines only while idle in input mode: a read transfer
      // turns the port to output at row fall and must never meet our driver
      serial_data_io_oe <= shift_ok;
      case (state_q)
        // boundaries never touched
        // only transfer cycles are issued, so no stop-register set ever runs
        S_IDLE: begin
          if (CMD_VALID) begin
            if (cmd_bad) begin
              CMD_ERR   <= 1'b1;
              CMD_READY <= 1'b1;
            end else begin
              op_q   <= CMD_OP;
              row_q  <= CMD_ROW;
              col_q  <= CMD_COL;
              mask_q <= CMD_MASK;
              cnt_q  <= 4'h0;
              state_q <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          // hold off until serial clock low and, for a normal transfer, setup met
          // split window
          if (!serial_shift_clock && (op_q[1] || sts_q == 4'h0) &&
              (cnt_q >= CYC_SRD || !last_wr_q)) begin
            transfer_output_enable_n <= 1'b0;
            write_mask_enable_n      <= ~op_q[0];
            special_function_select  <= op_q[1];
            address                  <= row_q;
            mask_data_lines          <= op_q[0] ? mask_q : `MPXFR_ALL_MASKED;
            mask_data_oe             <= op_q[0];
            serial_data_io_oe        <= 1'b0;
            state_q                  <= S_RAS;
            cnt_q                    <= 4'h0;
          end else if (cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        S_RAS: begin
          row_strobe_n <= 1'b0;
          cnt_q        <= cnt_q + 4'h1;
          // column address settles a cycle before the column strobe falls
          if (cnt_q == CYC_ADR) begin
            address <= col_q;
          end
          if (cnt_q == CYC_RAS) begin
            column_strobe_n <= 1'b0;
            mask_data_oe    <= 1'b0;
            cnt_q           <= 4'h0;
            state_q         <= S_CAS;
          end
        end
        S_CAS: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == CYC_CAS) begin
            // output enable rises before strobes, clock held off
            // no real-time read
            // the serial clock is held low here, so no tight alignment is needed
            transfer_output_enable_n <= 1'b1;
          end
          if (cnt_q == CYC_END) begin
            row_strobe_n        <= 1'b1;
            column_strobe_n     <= 1'b1;
            write_mask_enable_n <= 1'b1;
            cnt_q               <= 4'h0;
            state_q             <= S_PRE;
          end
        end
        S_PRE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == CYC_PRE) begin
            if (!op_q[1]) begin
              SERIAL_IS_INPUT <= op_q[0];
              normal_done_q   <= 1'b1;
            end
            last_wr_q <= op_q[0];
            CMD_READY <= 1'b1;
            state_q   <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [test/mpxfr_chk_assertions.sv]
// Purpose: pin-level checks on the transfer controller
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every controller instance
`timescale 1ns/1ns
`default_nettype none
module mpxfr_chk (
  input wire       CLK_SYS,
  input wire       RESET,
  input wire [1:0] CMD_OP,
  input wire       CMD_READY,
  input wire       CMD_ERR,
  input wire       SERIAL_IS_INPUT,
  input wire       row_strobe_n,
  input wire       column_strobe_n,
  input wire       transfer_output_enable_n,
  input wire       write_mask_enable_n,
  input wire       mask_data_oe,
  input wire       serial_shift_clock,
  input wire       serial_data_io_oe
);
  reg norm_q;
  reg cas_q;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      norm_q <= 1'b0;
      cas_q  <= 1'b0;
    end else begin
      if (CMD_READY && !CMD_ERR && !CMD_OP[1]) norm_q <= 1'b1;
      cas_q <= !row_strobe_n && (cas_q || !column_strobe_n);
    end
  end
  a_split_refused: assert property (CMD_READY && CMD_OP[1] && !norm_q |-> CMD_ERR)
    else $error("split taken before a normal transfer");
  a_refuse_quiet: assert property (CMD_ERR |-> row_strobe_n && $past(row_strobe_n))
    else $error("refused command moved the row strobe");
  a_cas_in_cycle: assert property ($rose(row_strobe_n) |-> cas_q)
    else $error("row cycle ended without a column strobe");
  a_decode_at_row: assert property ($fell(row_strobe_n) |-> column_strobe_n && !transfer_output_enable_n)
    else $error("bad transfer decode at row fall");
  a_mask_driven: assert property ($fell(row_strobe_n) && !write_mask_enable_n |-> mask_data_oe)
    else $error("write transfer without mask driven");
  a_sclk_still_row: assert property (!row_strobe_n |-> $stable(serial_shift_clock))
    else $error("serial clock moved in a row cycle");
  a_sclk_row_gap: assert property ($rose(row_strobe_n) |-> (!$rose(serial_shift_clock))[*2])
    else $error("serial clock rose too soon after row rise");
  a_sio_input_only: assert property (serial_data_io_oe |-> SERIAL_IS_INPUT)
    else $error("serial data driven outside input mode");
  c_refused: cover property (CMD_ERR);
  c_wr_xfer: cover property ($fell(row_strobe_n) && !write_mask_enable_n);
  c_shift: cover property ($rose(serial_shift_clock) && serial_data_io_oe);
endmodule
bind mpxfr_ctrl mpxfr_chk i_mpxfr_chk (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .CMD_OP(CMD_OP), .CMD_READY(CMD_READY),
  .CMD_ERR(CMD_ERR), .SERIAL_IS_INPUT(SERIAL_IS_INPUT), .row_strobe_n(row_strobe_n),
  .column_strobe_n(column_strobe_n), .transfer_output_enable_n(transfer_output_enable_n),
  .write_mask_enable_n(write_mask_enable_n), .mask_data_oe(mask_data_oe),
  .serial_shift_clock(serial_shift_clock), .serial_data_io_oe(serial_data_io_oe));
`default_nettype wire

// [test/mpxfr_mem_model.sv]
// Purpose: behavioural transfer side of the video memory
// Assumes: strobes and serial clock come from the controller
// Notes:   no array contents; decode and serial capture only
`timescale 1ns/1ns
`default_nettype none
module mpxfr_mem_model (
  input wire       row_strobe_n,
  input wire       column_strobe_n,
  input wire       transfer_output_enable_n,
  input wire       write_mask_enable_n,
  input wire       special_function_select,
  input wire [8:0] address,
  input wire [7:0] mask_data_lines,
  input wire       serial_shift_clock,
  input wire [7:0] serial_data_io_out,
  input wire       serial_data_io_oe,
  output reg       active_half_flag
);
  reg [1:0] op_q;
  reg [8:0] row_q;
  reg [8:0] col_q;
  reg [7:0] msk_q;
  reg       sio_in_q;
  reg [7:0] rx_n;
  reg [7:0] rx_q [0:15];
  // page read and refresh
  // neither cycle is ever issued by the controller, so neither is modelled
  initial begin
    active_half_flag = 1'b0;
    // port wakes up in input mode, so the first read must turn it
    sio_in_q = 1'b1;
    rx_n = 8'h00;
  end
  always @(negedge row_strobe_n) begin
    if (column_strobe_n && !transfer_output_enable_n) begin
      op_q = {special_function_select, !write_mask_enable_n};
      row_q = address;
      msk_q = mask_data_lines;
      // only full transfers turn the port
      if (!special_function_select) sio_in_q = !write_mask_enable_n;
    end
  end
  // tap from the latest column strobe
  always @(negedge column_strobe_n) begin
    if (!row_strobe_n) col_q = address;
  end
  always @(posedge serial_shift_clock) begin
    if (sio_in_q && serial_data_io_oe && rx_n < 8'h10) rx_q[rx_n[3:0]] = serial_data_io_out;
    rx_n = rx_n + 8'h01;
    if (rx_n == 8'h00) active_half_flag = !active_half_flag;
  end
endmodule
`default_nettype wire

// [test/testbench.sv]
// Purpose: self-checking bench for the transfer controller
// Assumes: inputs change 1 ns after the rising edge
// Notes:   results judged from the memory model state, CMD_ERR, SERIAL_IS_INPUT and the count of words taken on WR_READY
`timescale 1ns/1ns
`default_nettype none
module testbench;
  reg        CLK_SYS = 1'b0;
  reg        RESET = 1'b1;
  reg        CMD_VALID = 1'b0;
  reg  [1:0] CMD_OP = 2'h0;
  reg  [8:0] CMD_ROW = 9'h000;
  reg  [8:0] CMD_COL = 9'h000;
  reg  [7:0] CMD_MASK = 8'h00;
  reg        WR_VALID = 1'b0;
  reg  [7:0] WR_DATA = 8'h00;
  wire       CMD_READY, CMD_ERR, WR_READY, SERIAL_IS_INPUT;
  wire       row_n, col_n, xoe_n, wme_n, sfs, sck, soe, flag;
  wire [8:0] addr;
  wire [7:0] mask, serial_data_io;
  integer    error_cnt = 0;
  integer    num_checks = 0;
  integer    i;
  reg        err;
  always #10 CLK_SYS = ~CLK_SYS;
  mpxfr_ctrl i_mpxfr_ctrl (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
    .CMD_ROW(CMD_ROW), .CMD_COL(CMD_COL), .CMD_MASK(CMD_MASK), .CMD_READY(CMD_READY),
    .CMD_ERR(CMD_ERR), .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_DATA(WR_DATA),
    .SERIAL_IS_INPUT(SERIAL_IS_INPUT), .row_strobe_n(row_n), .column_strobe_n(col_n),
    .transfer_output_enable_n(xoe_n), .write_mask_enable_n(wme_n),
    .special_function_select(sfs), .address(addr), .mask_data_lines(mask),
    .mask_data_oe(), .serial_shift_clock(sck), .serial_data_io_out(serial_data_io),
    .serial_data_io_oe(soe), .active_half_flag(flag));
  mpxfr_mem_model i_mpxfr_mem_model (
    .row_strobe_n(row_n), .column_strobe_n(col_n), .transfer_output_enable_n(xoe_n),
    .write_mask_enable_n(wme_n), .special_function_select(sfs), .address(addr),
    .mask_data_lines(mask), .serial_shift_clock(sck), .serial_data_io_out(serial_data_io),
    .serial_data_io_oe(soe), .active_half_flag(flag));
  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task bound(input integer n, input integer lim);
    begin
      if (n >= lim) begin
        error_cnt = error_cnt + 1;
        close_out;
      end
    end
  endtask
  task run_cmd(input [1:0] op, input [8:0] row, input [8:0] col, input [7:0] msk);
    integer n;
    begin
      @(posedge CLK_SYS);
      #1;
      CMD_VALID = 1'b1;
      CMD_OP = op;
      CMD_ROW = row;
      CMD_COL = col;
      CMD_MASK = msk;
      n = 0;
      while (CMD_READY !== 1'b1 && n < 300) begin
        @(posedge CLK_SYS);
        #1;
        n = n + 1;
      end
      err = CMD_ERR;
      CMD_VALID = 1'b0;
      bound(n, 300);
    end
  endtask
  task t_refuse;
    begin
      for (i = 2; i < 4; i = i + 1) begin
        run_cmd(i[1:0], 9'h010, 9'h020, 8'hFF);
        chk(err, 1'b1);
      end
      $display("t_refuse done");
    end
  endtask
  task t_fill;
    reg     rdy;
    integer k;
    begin
      k = 0;
      WR_VALID = 1'b1;
      for (i = 0; i < 24; i = i + 1) begin
        WR_DATA = k[7:0];
        rdy = WR_READY;
        @(posedge CLK_SYS);
        #1;
        if (rdy === 1'b1) k = k + 1;
      end
      WR_VALID = 1'b0;
      // sixteen stored words plus the output register
      chk(k, 17);
      chk(i_mpxfr_mem_model.rx_n, 0);
      $display("t_fill done");
    end
  endtask
  task t_xfr(input [1:0] op, input [8:0] row, input [8:0] col, input [7:0] msk, input dir);
    begin
      run_cmd(op, row, col, msk);
      chk(err, 1'b0);
      chk(i_mpxfr_mem_model.op_q, op);
      chk(i_mpxfr_mem_model.row_q, row);
      chk(i_mpxfr_mem_model.col_q, col);
      chk(i_mpxfr_mem_model.sio_in_q, dir);
      chk(SERIAL_IS_INPUT, dir);
      if (op[0]) chk(i_mpxfr_mem_model.msk_q, msk);
      $display("t_xfr op %0d done", op);
    end
  endtask
  task t_drain;
    integer n;
    begin
      n = 0;
      while (i_mpxfr_mem_model.rx_n < 8'h10 && n < 1000) begin
        @(posedge CLK_SYS);
        n = n + 1;
      end
      bound(n, 1000);
      for (i = 0; i < 16; i = i + 1)
        chk(i_mpxfr_mem_model.rx_q[i], i);
      $display("t_drain done");
    end
  endtask
  initial begin
    repeat (2) @(posedge CLK_SYS);
    #1;
    RESET = 1'b0;
    t_refuse;
    t_fill;
    t_xfr(2'h0, 9'h1A5, 9'h03C, 8'hFF, 1'b0);
    t_xfr(2'h2, 9'h0FF, 9'h080, 8'hFF, 1'b0);
    t_xfr(2'h1, 9'h100, 9'h000, 8'h00, 1'b1);
    t_xfr(2'h3, 9'h001, 9'h1FF, 8'h5A, 1'b1);
    t_drain;
    t_xfr(2'h0, 9'h1FF, 9'h0F0, 8'hFF, 1'b0);
    close_out;
  end
endmodule
`default_nettype wire
